// ### include/bpc_pkg.sv
// constants, field layouts and carrier types for battery protection control
// =====================================================================
// Overview of operation
// - charge fault on overvoltage, overtemperature or overcurrent
// - charge FET stays on above 50 mA discharge
// - charge FET back on once causes clear, overcurrent only below 256 mA
// - discharge fault on overdischarge or overload
// - discharge FET stays on at 50 mA charge and above
// - discharge FET back on once causes clear, overload only below 256 mA discharge
// - optional confirmation by two consecutive measurements
// - front-end trips clear at zero average current while awake
// - short-circuit delay nibbles per direction
// - sleep releases short circuit after 20 s
// - safety trip latches until power-on reset
// - safety trip on sustained pack overvoltage
// - safety trip on sustained overtemperature
// - safety trip when front-end failures reach limit
// - periodic front-end check counts mismatches
// - charge fault set on three causes
// - sleep after quiet bus and low current
// - sleep wakes for measurements periodically
// - bus edge or current leaves sleep
// - configuration loaded before operation at power-up
// - partial reset rewrites front end, clears ed2 and dsg_flag
package bpc_pkg;
	// =================================================================
	// timing
	localparam int BPC_CLK_PERIOD_NS = 5;
	localparam int BPC_NS_PER_S      = 1_000_000_000;
	localparam int BPC_CYCLES_PER_S  = BPC_NS_PER_S / BPC_CLK_PERIOD_NS;
	localparam int BPC_SAFE_QUAL_S   = 1;
	localparam int BPC_OFF_QUAL_S    = 2;
	localparam int BPC_RECOVER_S     = 20;
	// first tick after a start may be short, hence one extra tick
	localparam logic [1:0] BPC_SAFE_TICKS = 2'(BPC_SAFE_QUAL_S + 1);
	localparam logic [1:0] BPC_OFF_TICKS  = 2'(BPC_OFF_QUAL_S + 1);
	localparam logic [4:0] BPC_REC_TICKS  = 5'(BPC_RECOVER_S + 1);
	localparam logic [3:0] BPC_BCAST_S    = 4'hA;
	// currents in mA, signed
	localparam logic signed [15:0] BPC_KEEP_MA   = 16'sh0032;
	localparam logic signed [15:0] BPC_REARM_MA  = 16'sh0100;
	// =================================================================
	// register offsets
	localparam logic [7:0] BPC_OFS_MISC   = 8'h00;
	localparam logic [7:0] BPC_OFS_LIM_A  = 8'h04;
	localparam logic [7:0] BPC_OFS_LIM_V  = 8'h08;
	localparam logic [7:0] BPC_OFS_LIM_S  = 8'h0C;
	localparam logic [7:0] BPC_OFS_AFE    = 8'h10;
	localparam logic [7:0] BPC_OFS_SLP    = 8'h14;
	localparam logic [7:0] BPC_OFS_MEAS_A = 8'h18;
	localparam logic [7:0] BPC_OFS_MEAS_V = 8'h1C;
	localparam logic [7:0] BPC_OFS_MEAS_T = 8'h20;
	localparam logic [7:0] BPC_OFS_FLAGS  = 8'h24;
	localparam logic [7:0] BPC_OFS_CMD    = 8'h28;
	localparam logic [7:0] BPC_OFS_STATUS = 8'h2C;
	// =================================================================
	// field positions
	localparam int BPC_MISC_DBL     = 0;
	localparam int BPC_MISC_NOSLEEP = 4;
	localparam int BPC_MISC_AFECHK  = 5;
	localparam int BPC_MEAS_OT      = 16;
	localparam int BPC_MEAS_OD      = 17;
	localparam int BPC_CMD_PRST     = 0;
	localparam int BPC_CMD_MISMATCH = 1;
	localparam int BPC_CMD_LOADED   = 2;
	// =================================================================
	// reset values
	localparam logic [7:0]  BPC_MISC_RST  = 8'h00;
	localparam logic [31:0] BPC_LIM_A_RST = 32'h1388_0FA0;
	localparam logic [31:0] BPC_LIM_V_RST = 32'h1068_41A0;
	localparam logic [31:0] BPC_LIM_S_RST = 32'h0C80_4650;
	localparam logic [31:0] BPC_AFE_RST   = 32'h050A_0211;
	localparam logic [31:0] BPC_SLP_RST   = 32'h001E_000A;
	// =================================================================
	// types
	typedef enum logic {BPC_AWAKE, BPC_ASLEEP} bpc_mode_type;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} bpc_apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} bpc_apb_resp_type;
	typedef struct packed {
		logic chg_fet_on;
		logic dsg_fet_on;
		logic fet_update;
		logic afe_rewrite;
		logic check_due;
		logic wake_vt;
		logic wake_cur;
		logic asleep;
		logic cfg_load_req;
	} bpc_afe_cmd_type;
endpackage : bpc_pkg

// ### src/bpc_tick.sv
// seconds tick generator for battery protection control
`timescale 1ns/1ps
`default_nettype none
module bpc_tick
	import bpc_pkg::*;
#(
	parameter int TICK_CYCLES = BPC_CYCLES_PER_S
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	output var  logic tick
);
	localparam int W = $clog2(TICK_CYCLES);
	localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 2) begin : g_bad
		$error("bpc_tick: TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} bpc_tick_state_type;

	bpc_tick_state_type st;
	bpc_tick_state_type next_st;

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (st.cnt == LAST) begin
			next_st.cnt  = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	AST_TICK_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		ce && tick |=> !tick) else $error("tick wider than one cycle");
endmodule : bpc_tick
`default_nettype wire

// ### src/bpc_ctrl.sv
// protection control core: fault flags, FET commands, safety trip, sleep
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bpc_ctrl
	import bpc_pkg::*;
#(
	parameter int TICK_CYCLES = BPC_CYCLES_PER_S
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire bpc_apb_req_type  apb_req,
	output var  bpc_apb_resp_type apb_resp,
	input  wire logic             bus_clock_line,
	input  wire logic             bus_data_line,
	input  wire logic             front_end_alert_in,
	output var  bpc_afe_cmd_type  afe_cmd,
	output var  logic             safety_out_n
);
	// =================================================================
	// state
	typedef struct packed {
		logic [1:0]   bc;
		logic [1:0]   bd;
		logic [1:0]   al;
		logic         bc_q;
		logic         bd_q;
		logic         ack;
		logic [31:0]  prdata;
		logic         pslverr;
		logic [7:0]   misc;
		logic [31:0]  lim_a;
		logic [31:0]  lim_v;
		logic [31:0]  lim_s;
		logic [31:0]  afe;
		logic [31:0]  slp;
		logic [31:0]  meas_a;
		logic [31:0]  meas_v;
		logic [17:0]  meas_t;
		logic         meas_new;
		logic         loaded;
		logic         cf;
		logic         cf_oc;
		logic         cf_pend;
		logic         df;
		logic         df_ol;
		logic         df_pend;
		logic         chg_on;
		logic         dsg_on;
		logic         fet_upd;
		logic         afe_rw;
		logic         tripped;
		logic [1:0]   sv_cnt;
		logic [1:0]   st_cnt;
		logic [7:0]   fail_cnt;
		logic [15:0]  chk_cnt;
		logic         chk_due;
		bpc_mode_type mode;
		logic [1:0]   off_cnt;
		logic [7:0]   slp_cnt;
		logic [7:0]   cur_cnt;
		logic         wake_vt;
		logic         wake_cur;
		logic [3:0]   trip_cnt;
		logic         trip_chg;
		logic         trip_dsg;
		logic [4:0]   rec_cnt;
		logic         ed2;
		logic         valid_discharge_flag;
		logic         dsg_flag;
		logic [3:0]   bcast;
	} bpc_state_type;

	bpc_state_type st;
	bpc_state_type next_st;
	logic          tick;

	bpc_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.tick    (tick)
	);

	// =================================================================
	// measurements and raw conditions
	logic signed [15:0] avg;
	logic [15:0]        cur_mag;
	logic               ov;
	logic               ot;
	logic               poc;
	logic               od;
	logic               ol;
	logic               rd;
	logic               wr;
	logic [7:0]         ad;
	logic               rise;
	logic               off_ok;
	logic               trip_dir;
	logic [3:0]         trip_dly;
	logic [15:0]        chk_lim;

	assign avg     = $signed(st.meas_a[15:0]);
	assign cur_mag = st.meas_a[31] ? 16'(-st.meas_a[31:16])
		: st.meas_a[31:16];
	assign ov      = (st.meas_v[15:0] >= st.lim_v[15:0])
		|| (st.meas_v[31:16] >= st.lim_v[31:16]);
	assign ot      = st.meas_t[BPC_MEAS_OT];
	assign poc     = avg >= $signed(st.lim_a[15:0]);
	assign od      = st.meas_t[BPC_MEAS_OD];
	assign ol      = avg <= -$signed(st.lim_a[31:16]);
	assign ad      = apb_req.paddr;
	assign rd      = apb_req.psel && apb_req.penable && !st.ack;
	assign wr      = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& st.ack;

	always_comb begin
		logic        hit;
		logic [31:0] rdata;
		logic        dbl;
		hit      = 1'b1;
		rdata    = '0;
		next_st  = st;
		dbl      = st.misc[BPC_MISC_DBL];
		// =============================================================
		// pin synchronisers
		next_st.bc   = {st.bc[0], bus_clock_line};
		next_st.bd   = {st.bd[0], bus_data_line};
		next_st.al   = {st.al[0], front_end_alert_in};
		next_st.bc_q = st.bc[1];
		next_st.bd_q = st.bd[1];
		rise = (st.bc[1] && !st.bc_q) || (st.bd[1] && !st.bd_q);
		// =============================================================
		// apb slave: data captured in the first access cycle,
		// pready and the write follow one cycle later
		if (ad == BPC_OFS_MISC) rdata = {24'h000000, st.misc};
		else if (ad == BPC_OFS_LIM_A) rdata = st.lim_a;
		else if (ad == BPC_OFS_LIM_V) rdata = st.lim_v;
		else if (ad == BPC_OFS_LIM_S) rdata = st.lim_s;
		else if (ad == BPC_OFS_AFE) rdata = st.afe;
		else if (ad == BPC_OFS_SLP) rdata = st.slp;
		else if (ad == BPC_OFS_MEAS_A) rdata = st.meas_a;
		else if (ad == BPC_OFS_MEAS_V) rdata = st.meas_v;
		else if (ad == BPC_OFS_MEAS_T) rdata = {14'h0000, st.meas_t};
		else if (ad == BPC_OFS_FLAGS)
			rdata = {29'h00000000, st.dsg_flag, st.valid_discharge_flag, st.ed2};
		else if (ad == BPC_OFS_CMD) rdata = '0;
		else if (ad == BPC_OFS_STATUS)
			rdata = {8'h00, st.fail_cnt, st.bcast, 3'h0, st.loaded,
				st.trip_dsg, st.trip_chg, st.mode == BPC_ASLEEP,
				st.dsg_on, st.chg_on, st.tripped, st.df, st.cf};
		else hit = 1'b0;
		next_st.ack = rd;
		if (rd) begin
			next_st.prdata  = hit ? rdata : '0;
			next_st.pslverr = !hit;
		end
		next_st.meas_new = 1'b0;
		next_st.afe_rw   = 1'b0;
		if (wr) begin
			if (ad == BPC_OFS_MISC) next_st.misc = apb_req.pwdata[7:0];
			else if (ad == BPC_OFS_LIM_A) next_st.lim_a = apb_req.pwdata;
			else if (ad == BPC_OFS_LIM_V) next_st.lim_v = apb_req.pwdata;
			else if (ad == BPC_OFS_LIM_S) next_st.lim_s = apb_req.pwdata;
			else if (ad == BPC_OFS_AFE) next_st.afe = apb_req.pwdata;
			else if (ad == BPC_OFS_SLP) next_st.slp = apb_req.pwdata;
			else if (ad == BPC_OFS_MEAS_A) next_st.meas_a = apb_req.pwdata;
			else if (ad == BPC_OFS_MEAS_V) next_st.meas_v = apb_req.pwdata;
			else if (ad == BPC_OFS_MEAS_T) begin
				next_st.meas_t   = apb_req.pwdata[17:0];
				next_st.meas_new = 1'b1;
			end else if (ad == BPC_OFS_FLAGS) begin
				next_st.ed2      = apb_req.pwdata[0];
				next_st.valid_discharge_flag      = apb_req.pwdata[1];
				next_st.dsg_flag = apb_req.pwdata[2];
			end else if (ad == BPC_OFS_CMD) begin
				if (apb_req.pwdata[BPC_CMD_LOADED])
					next_st.loaded = 1'b1;
				if (apb_req.pwdata[BPC_CMD_MISMATCH]
					&& st.fail_cnt != 8'hFF)
					next_st.fail_cnt = st.fail_cnt + 8'h01;
				if (apb_req.pwdata[BPC_CMD_PRST]) begin
					next_st.afe_rw   = 1'b1;
					next_st.ed2      = 1'b0;
					next_st.dsg_flag = 1'b0;
					next_st.bcast    = BPC_BCAST_S;
				end
			end
		end
		// =============================================================
		// fault flags, judged one cycle after a temperature write
		// so that every measurement register is current
		if (st.meas_new && st.loaded) begin
			if (!ov && !ot && (!st.cf_oc || avg < BPC_REARM_MA)) begin
				next_st.cf    = 1'b0;
				next_st.cf_oc = 1'b0;
			end
			if (!od && (!st.df_ol || avg > -BPC_REARM_MA)) begin
				next_st.df    = 1'b0;
				next_st.df_ol = 1'b0;
			end
			next_st.cf_pend = ov || ot || poc;
			if ((ov || ot || poc) && (!dbl || st.cf_pend)) begin
				next_st.cf    = 1'b1;
				next_st.cf_oc = poc;
			end
			next_st.df_pend = od || ol;
			if ((od || ol) && (!dbl || st.df_pend)) begin
				next_st.df    = 1'b1;
				next_st.df_ol = ol;
			end
		end
		// =============================================================
		// front-end trips: direction from the sign of the current
		trip_dir = avg > 16'sh0000;
		trip_dly = trip_dir ? st.afe[7:4] : st.afe[3:0];
		if (!st.al[1]) next_st.trip_cnt = '0;
		else if (tick && st.trip_cnt != 4'hF)
			next_st.trip_cnt = st.trip_cnt + 4'h1;
		if (!(st.trip_chg || st.trip_dsg) || st.mode == BPC_AWAKE)
			next_st.rec_cnt = '0;
		else if (tick && st.rec_cnt != BPC_REC_TICKS)
			next_st.rec_cnt = st.rec_cnt + 5'h01;
		if ((st.mode == BPC_AWAKE && avg == 16'sh0000)
			|| (st.mode == BPC_ASLEEP && st.rec_cnt == BPC_REC_TICKS)) begin
			next_st.trip_chg = 1'b0;
			next_st.trip_dsg = 1'b0;
		end
		if (st.al[1] && st.trip_cnt >= trip_dly) begin
			if (trip_dir) next_st.trip_chg = 1'b1;
			else next_st.trip_dsg = 1'b1;
		end
		// =============================================================
		// FET commands
		next_st.chg_on = !(st.cf && !(avg < -BPC_KEEP_MA))
			&& !st.trip_chg;
		next_st.dsg_on = !(st.df && !(avg >= BPC_KEEP_MA))
			&& !st.trip_dsg;
		next_st.fet_upd = (next_st.chg_on != st.chg_on)
			|| (next_st.dsg_on != st.dsg_on);
		// =============================================================
		// safety trip, released only by reset
		if (!(st.cf && st.meas_v[15:0] > st.lim_s[15:0])) next_st.sv_cnt = '0;
		else if (tick && st.sv_cnt != BPC_SAFE_TICKS)
			next_st.sv_cnt = st.sv_cnt + 2'h1;
		if (!(st.cf && st.meas_t[15:0] > st.lim_s[31:16])) next_st.st_cnt = '0;
		else if (tick && st.st_cnt != BPC_SAFE_TICKS)
			next_st.st_cnt = st.st_cnt + 2'h1;
		if (st.sv_cnt == BPC_SAFE_TICKS || st.st_cnt == BPC_SAFE_TICKS
			|| (st.misc[BPC_MISC_AFECHK]
			&& st.fail_cnt >= st.afe[15:8]))
			next_st.tripped = 1'b1;
		// =============================================================
		// front-end check period, stretched while asleep
		chk_lim = (st.mode == BPC_ASLEEP)
			? st.afe[23:16] * st.afe[31:24] : {8'h00, st.afe[23:16]};
		next_st.chk_due = 1'b0;
		if (tick) begin
			if (st.chk_cnt + 16'h0001 >= chk_lim) begin
				next_st.chk_cnt = '0;
				next_st.chk_due = 1'b1;
			end else begin
				next_st.chk_cnt = st.chk_cnt + 16'h0001;
			end
		end
		// =============================================================
		// sleep mode
		off_ok = !st.bc[1] && !st.bd[1] && cur_mag < st.slp[15:0]
			&& !st.misc[BPC_MISC_NOSLEEP];
		if (!off_ok || st.mode == BPC_ASLEEP) next_st.off_cnt = '0;
		else if (tick && st.off_cnt != BPC_OFF_TICKS)
			next_st.off_cnt = st.off_cnt + 2'h1;
		next_st.wake_vt  = 1'b0;
		next_st.wake_cur = 1'b0;
		case (st.mode)
			BPC_AWAKE: begin
				next_st.slp_cnt = '0;
				next_st.cur_cnt = '0;
				if (off_ok && st.off_cnt == BPC_OFF_TICKS)
					next_st.mode = BPC_ASLEEP;
			end
			BPC_ASLEEP: begin
				if (tick) begin
					next_st.slp_cnt = st.slp_cnt + 8'h01;
					next_st.cur_cnt = st.cur_cnt + 8'h01;
					if (st.slp_cnt + 8'h01 >= st.slp[23:16]) begin
						next_st.slp_cnt = '0;
						next_st.wake_vt = 1'b1;
					end
					if (st.cur_cnt + 8'h01 >= st.afe[31:24]) begin
						next_st.cur_cnt  = '0;
						next_st.wake_cur = 1'b1;
					end
				end
				if (rise || cur_mag > st.slp[15:0])
					next_st.mode = BPC_AWAKE;
			end
			default: next_st.mode = BPC_AWAKE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st        <= '0;
			st.misc   <= BPC_MISC_RST;
			st.lim_a  <= BPC_LIM_A_RST;
			st.lim_v  <= BPC_LIM_V_RST;
			st.lim_s  <= BPC_LIM_S_RST;
			st.afe    <= BPC_AFE_RST;
			st.slp    <= BPC_SLP_RST;
			st.chg_on <= 1'b1;
			st.dsg_on <= 1'b1;
			st.bcast  <= BPC_BCAST_S;
			st.mode   <= BPC_AWAKE;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// =================================================================
	// outputs, all straight from state
	assign apb_resp     = {st.prdata, st.ack, st.pslverr};
	assign afe_cmd      = {st.chg_on, st.dsg_on, st.fet_upd, st.afe_rw,
		st.chk_due, st.wake_vt, st.wake_cur, st.mode == BPC_ASLEEP,
		!st.loaded};
	assign safety_out_n = !st.tripped;

	// =================================================================
	// checks
	sequence s_prst_req;
		ce && wr && ad == BPC_OFS_CMD && apb_req.pwdata[BPC_CMD_PRST];
	endsequence
	sequence s_prst_done;
		afe_cmd.afe_rewrite && !st.ed2 && !st.dsg_flag
			&& st.bcast == BPC_BCAST_S;
	endsequence

	AST_SAFE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		!safety_out_n |=> !safety_out_n) else $error("safety released");
	AST_SAFE_AC: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st.misc[BPC_MISC_AFECHK] && st.fail_cnt >= st.afe[15:8]
		|=> !safety_out_n) else $error("failure limit did not trip");
	AST_CHG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st.cf && !(avg < -BPC_KEEP_MA) |=> !afe_cmd.chg_fet_on)
		else $error("charge FET left on under fault");
	AST_CHG_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !st.trip_chg && avg < -BPC_KEEP_MA |=> afe_cmd.chg_fet_on)
		else $error("charge FET off during discharge");
	AST_DSG_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !st.trip_dsg && avg >= BPC_KEEP_MA |=> afe_cmd.dsg_fet_on)
		else $error("discharge FET off during charge");
	AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		ce && afe_cmd.asleep && st.bc[1] && !st.bc_q |=> !afe_cmd.asleep)
		else $error("bus edge did not end sleep");
	AST_PRST: assert property (@(posedge pclk) disable iff (!presetn)
		s_prst_req |=> s_prst_done) else $error("partial reset incomplete");
	AST_SLEEP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		!afe_cmd.asleep && st.misc[BPC_MISC_NOSLEEP] |=> !afe_cmd.asleep)
		else $error("sleep entered while disabled");
	AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		ce && apb_req.psel && apb_req.penable && !apb_resp.pready
		|=> apb_resp.pready ##1 !apb_resp.pready)
		else $error("apb answer not one wait state");
endmodule : bpc_ctrl
`default_nettype wire

// ### tb/bpc_afe_model.sv
// front-end partner model: alert output and FET command watcher
`timescale 1ns/1ps
`default_nettype none
module bpc_afe_model
	import bpc_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            trip_req,
	input  wire bpc_afe_cmd_type afe_cmd,
	output var  logic            front_end_alert_in,
	output var  int              n_updates
);
	// =========================================================
	// alert is a level that lasts as long as the breach lasts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			front_end_alert_in <= 1'b0;
			n_updates          <= 0;
		end else begin
			front_end_alert_in <= trip_req;
			if (afe_cmd.fet_update) begin
				n_updates <= n_updates + 1;
			end
		end
	end
endmodule : bpc_afe_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the protection control core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, v) begin n_checks++; if ((v) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, v); end end
module tb_top
	import bpc_pkg::*;
;
	// =========================================================
	// signals
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	bpc_apb_req_type  req = '0;
	bpc_apb_resp_type resp;
	bpc_afe_cmd_type  cmd;
	logic             bcl = 1'b1;
	logic             bdl = 1'b1;
	logic             bus_lvl = 1'b1;
	int               n_due = 0;
	int               n_wvt = 0;
	int               n_wcur = 0;
	logic             alert;
	logic             safe_n;
	logic             trip_req = 1'b0;
	logic             lk_run = 1'b0;
	logic [2:0]       lk_cnt = 3'h0;
	logic [31:0]      r;
	int               n_upd;
	int               n_rw = 0;
	int               failures = 0;
	int               n_checks = 0;
	// short second so the run stays small
	bpc_ctrl #(.TICK_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .apb_req(req), .apb_resp(resp), .bus_clock_line(bcl),
		.bus_data_line(bdl), .front_end_alert_in(alert), .afe_cmd(cmd),
		.safety_out_n(safe_n));
	bpc_afe_model FE (.pclk(pclk), .presetn(presetn), .trip_req(trip_req),
		.afe_cmd(cmd), .front_end_alert_in(alert), .n_updates(n_upd));
	always #2.5 pclk = ~pclk;
	// bus clock line toggles every 8 cycles: 80 ns period
	always @(posedge pclk) begin
		if (lk_run) begin
			lk_cnt <= lk_cnt + 3'h1;
			if (lk_cnt == 3'h7) begin
				bcl <= !bcl;
			end
		end else begin
			// parked between frames so that only this block drives the line
			bcl <= bus_lvl;
		end
		if (cmd.afe_rewrite) begin
			n_rw <= n_rw + 1;
		end
		n_due  <= n_due + int'(cmd.check_due);
		n_wvt  <= n_wvt + int'(cmd.wake_vt);
		n_wcur <= n_wcur + int'(cmd.wake_cur);
	end
	// =========================================================
	// bus tasks
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (resp.pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			failures++;
			test_done();
		end
		r = resp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	task automatic rst;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst
	// status polled until masked bits match, bounded
	task automatic poll(input logic [31:0] m, input logic [31:0] e);
		int i;
		rd(BPC_OFS_STATUS);
		for (i = 0; i < 40 && (r & m) !== e; i++) begin
			rd(BPC_OFS_STATUS);
		end
		`CHK("status", e, r & m)
	endtask : poll
	// measurement round: f = faults {dsg,chg}, e = FETs {dsg,chg}
	task automatic step(input logic [15:0] v, input logic [15:0] a,
			input logic [31:0] t, input logic [1:0] f, input logic [1:0] e);
		wr(BPC_OFS_MEAS_A, {a, a});
		wr(BPC_OFS_MEAS_V, {16'h0000, v});
		wr(BPC_OFS_MEAS_T, t);
		rd(BPC_OFS_STATUS);
		`CHK("status", {e, f}, {r[4:3], r[1:0]})
		`CHK("fets", e, {cmd.dsg_fet_on, cmd.chg_fet_on})
	endtask : step
	// =========================================================
	// scenarios
	task automatic t_reset;
		logic [7:0]  o [4] = '{BPC_OFS_LIM_A, BPC_OFS_LIM_V, BPC_OFS_LIM_S,
			BPC_OFS_AFE};
		logic [31:0] x [4] = '{BPC_LIM_A_RST, BPC_LIM_V_RST, BPC_LIM_S_RST,
			BPC_AFE_RST};
		`CHK("load_req", 1'b1, cmd.cfg_load_req)
		for (int i = 0; i < 4; i++) begin
			rd(o[i]);
			`CHK("reg", x[i], r)
		end
		rd(8'h30);
		`CHK("slverr", 1'b1, resp.pslverr)
		wr(BPC_OFS_CMD, 32'h0000_0004);
		`CHK("load_req", 1'b0, cmd.cfg_load_req)
	endtask : t_reset
	task automatic t_fet;
		step(16'h41A0, 16'h0000, 0, 2'b01, 2'b10);
		step(16'h4000, 16'h0000, 0, 2'b00, 2'b11);
		step(16'h41A0, 16'hFF9C, 0, 2'b01, 2'b11);
		step(16'h4000, 16'h0000, 32'h0001_0000, 2'b01, 2'b10);
		step(16'h4000, 16'h0FA0, 0, 2'b01, 2'b10);
		step(16'h4000, 16'h012C, 0, 2'b01, 2'b10);
		step(16'h4000, 16'h00C8, 0, 2'b00, 2'b11);
		step(16'h4000, 16'h0000, 32'h0002_0000, 2'b10, 2'b01);
		step(16'h4000, 16'h0064, 32'h0002_0000, 2'b10, 2'b11);
		step(16'h4000, 16'h0000, 0, 2'b00, 2'b11);
		step(16'h4000, 16'hEC78, 0, 2'b10, 2'b01);
		step(16'h4000, 16'hFED4, 0, 2'b10, 2'b01);
		step(16'h4000, 16'hFF38, 0, 2'b00, 2'b11);
		wr(BPC_OFS_MISC, 32'h0000_0001);
		step(16'h41A0, 16'h0000, 0, 2'b00, 2'b11);
		step(16'h41A0, 16'h0000, 0, 2'b01, 2'b10);
		wr(BPC_OFS_MISC, 32'h0000_0000);
		step(16'h4000, 16'h0000, 0, 2'b00, 2'b11);
		`CHK("updates", 1'b1, n_upd > 0)
	endtask : t_fet
	task automatic t_part;
		int k;
		wr(BPC_OFS_FLAGS, 32'h0000_0007);
		k = n_rw;
		wr(BPC_OFS_CMD, 32'h0000_0005);
		rd(BPC_OFS_FLAGS);
		`CHK("flags", 32'h0000_0002, r)
		`CHK("rewrite", 1, n_rw - k)
		rd(BPC_OFS_STATUS);
		`CHK("bcast", BPC_BCAST_S, r[15:12])
		`CHK("check_due", 1'b1, n_due > 0)
	endtask : t_part
	task automatic t_alert;
		wr(BPC_OFS_MEAS_A, 32'h0064_0064);
		trip_req <= 1'b1;
		poll(32'hC0, 32'h40);
		trip_req <= 1'b0;
		wr(BPC_OFS_MEAS_A, 32'h0);
		poll(32'hC0, 32'h00);
		wr(BPC_OFS_MEAS_A, 32'hFF9C_FF9C);
		trip_req <= 1'b1;
		poll(32'hC0, 32'h80);
		trip_req <= 1'b0;
		wr(BPC_OFS_MEAS_A, 32'h0);
		poll(32'hC0, 32'h00);
	endtask : t_alert
	task automatic t_sleep;
		wr(BPC_OFS_MEAS_A, 32'h0000_0064);
		wr(BPC_OFS_MISC, 32'h0000_0010);
		bus_lvl <= 1'b0;
		bdl <= 1'b0;
		repeat (80) @(posedge pclk);
		`CHK("asleep", 1'b0, cmd.asleep)
		wr(BPC_OFS_MISC, 32'h0000_0000);
		poll(32'h20, 32'h20);
		`CHK("asleep", 1'b1, cmd.asleep)
		// charge-side trip while asleep: only the recovery timer clears it
		trip_req <= 1'b1;
		poll(32'hC0, 32'h40);
		trip_req <= 1'b0;
		repeat (640) @(posedge pclk);
		poll(32'hE0, 32'h20);
		`CHK("wake_vt", 1'b1, n_wvt > 0)
		`CHK("wake_cur", 1'b1, n_wcur > 0)
		lk_run <= 1'b1;
		poll(32'h20, 32'h00);
		lk_run <= 1'b0;
		bus_lvl <= 1'b1;
		bdl <= 1'b1;
	endtask : t_sleep
	task automatic t_safe;
		step(16'h4700, 16'h0000, 0, 2'b01, 2'b10);
		poll(32'h4, 32'h4);
		wr(BPC_OFS_CMD, 32'h0000_0005);
		`CHK("safe_n", 1'b0, safe_n)
		rst();
		`CHK("safe_n", 1'b1, safe_n)
		wr(BPC_OFS_CMD, 32'h0000_0004);
		step(16'h4000, 16'h0000, 32'h0001_0D00, 2'b01, 2'b10);
		poll(32'h4, 32'h4);
		rst();
		wr(BPC_OFS_CMD, 32'h0000_0004);
		wr(BPC_OFS_MISC, 32'h0000_0020);
		wr(BPC_OFS_CMD, 32'h0000_0006);
		`CHK("safe_n", 1'b1, safe_n)
		wr(BPC_OFS_CMD, 32'h0000_0006);
		poll(32'h4, 32'h4);
		`CHK("safe_n", 1'b0, safe_n)
	endtask : t_safe
	// =========================================================
	// main sequence
	initial begin
		rst();
		t_reset();
		t_fet();
		t_part();
		t_alert();
		t_sleep();
		t_safe();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
